/* File: design/nand_host_ctrl.sv */
// Host controller that drives an asynchronous 8-bit NAND device through its pins
// How it works
// - Commands, addresses, data share one byte bus
// - Command latch high captures command byte
// - Address latch high captures address byte
// - Host strobes no faster than 25ns
// - Host must avoid erasing bad blocks
// - Address: two column then two row cycles; erase sends the two row cycles only
// - Read 00h/30h, program 80h/10h
// - Latch only with select low, strobe edge
`timescale 1ns/1ps
module nand_host_ctrl #(
	parameter int unsigned STROBE_HALF = nand_host_pkg::STROBE_CYCLES,
	parameter int unsigned BUSY_WAIT   = nand_host_pkg::READ_BUSY_CYCLES
) (
	input  wire logic                      I_REF_CLK,
	input  wire logic                      I_RST_N,
	input  wire logic                      i_req_valid,
	input  wire nand_host_pkg::request_t   i_req,
	input  wire logic                      i_bad_block,
	input  wire logic                      i_wr_valid,
	input  wire logic [7:0]                i_wr_data,
	input  wire logic [7:0]                i_shared_byte_bus,
	input  wire logic                      i_ready_busy,
	output logic                           o_req_ready,
	output logic                           o_wr_ready,
	output logic                           o_rd_valid,
	output logic [7:0]                     o_rd_data,
	output logic                           o_done,
	output logic                           o_error,
	output logic [7:0]                     o_shared_byte_bus,
	output logic                           o_shared_byte_bus_oe_n,
	output nand_host_pkg::strobes_t        o_pins
);
	import nand_host_pkg::*;

	typedef enum {
		IDLE, SETUP, ADDR, XFER, CONFIRM, WAIT_BUSY, WAIT_READY, READOUT, FINISH
	} state_t;

	state_t      state_q, state_d;
	request_t    req_q, req_d;
	strobes_t    pins_q, pins_d;
	logic [7:0]  bus_q, bus_d;
	logic        oe_n_q, oe_n_d;
	logic [2:0]  addr_idx_q, addr_idx_d;
	logic [11:0] cnt_q, cnt_d;
	logic [15:0] wait_q, wait_d;
	logic        phase_q, phase_d;
	logic        req_ready_q, req_ready_d;
	logic        wr_ready_q, wr_ready_d;
	logic        rd_valid_q, rd_valid_d;
	logic [7:0]  rd_data_q, rd_data_d;
	logic        done_q, done_d;
	logic        error_q, error_d;

	// Picks the address byte for the given cycle; erase sends row bytes only
	function automatic logic [7:0] addr_byte(input request_t r, input logic [2:0] idx);
		logic [2:0] k;
		k = (r.op == OP_ERASE) ? idx + 3'h2 : idx;
		case (k)
			3'h0: addr_byte = r.column[7:0];
			3'h1: addr_byte = {4'h0, r.column[11:8]};
			3'h2: addr_byte = r.row[7:0];
			default: addr_byte = r.row[15:8];
		endcase
	endfunction : addr_byte

	function automatic logic [7:0] setup_code(input logic [1:0] op);
		case (op)
			OP_READ:    setup_code = CMD_READ_SETUP;
			OP_PROGRAM: setup_code = CMD_PROG_SETUP;
			default:    setup_code = CMD_ERASE_SETUP;
		endcase
	endfunction : setup_code

	function automatic logic [7:0] confirm_code(input logic [1:0] op);
		case (op)
			OP_READ:    confirm_code = CMD_READ_CONFIRM;
			OP_PROGRAM: confirm_code = CMD_PROG_CONFIRM;
			default:    confirm_code = CMD_ERASE_CONFIRM;
		endcase
	endfunction : confirm_code

	always_comb begin
		logic strobe_done;
		logic [2:0] addr_last;
		strobe_done = (wait_q == 16'(STROBE_HALF - 1));
		addr_last   = (req_q.op == OP_ERASE) ? 3'(ROW_BYTES - 1)
			: 3'(COL_BYTES + ROW_BYTES - 1);
		state_d     = state_q;
		req_d       = req_q;
		pins_d      = pins_q;
		bus_d       = bus_q;
		oe_n_d      = oe_n_q;
		addr_idx_d  = addr_idx_q;
		cnt_d       = cnt_q;
		wait_d      = strobe_done ? 16'h0000 : wait_q + 16'h0001;
		phase_d     = phase_q;
		req_ready_d = 1'b0;
		wr_ready_d  = 1'b0;
		rd_valid_d  = 1'b0;
		rd_data_d   = rd_data_q;
		done_d      = 1'b0;
		error_d     = 1'b0;
		pins_d.protect_n = 1'b1;
		case (state_q)
			IDLE: begin
				pins_d.chip_sel_n = 1'b1;
				oe_n_d = 1'b1;
				wait_d = 16'h0000;
				req_ready_d = 1'b1;
				if (i_req_valid && req_ready_q) begin
					req_ready_d = 1'b0;
					if (i_req.op == OP_ERASE && i_bad_block) begin
						error_d = 1'b1;
						done_d  = 1'b1;
					end else begin
						req_d = i_req;
						if (i_req.op == OP_READ && i_req.count == 12'h000)
							req_d.count = 12'(PAGE_BYTES);
						pins_d.chip_sel_n = 1'b0;
						state_d = SETUP;
						phase_d = 1'b0;
						addr_idx_d = 3'h0;
					end
				end
			end
			SETUP, ADDR, CONFIRM, XFER: begin
				// Each byte is one low half of STROBE_HALF cycles and one high half of at least STROBE_HALF plus one
				if (!phase_q) begin
					pins_d.cle = (state_q == SETUP || state_q == CONFIRM);
					pins_d.ale = (state_q == ADDR);
					oe_n_d = 1'b0;
					if (state_q == SETUP) bus_d = setup_code(req_q.op);
					else if (state_q == CONFIRM) bus_d = confirm_code(req_q.op);
					else if (state_q == ADDR) bus_d = addr_byte(req_q, addr_idx_q);
					else bus_d = i_wr_data;
					if (state_q != XFER || i_wr_valid) begin
						pins_d.write_strobe_n = 1'b0;
						wr_ready_d = (state_q == XFER);
						phase_d = 1'b1;
						wait_d = 16'h0000;
					end
				end else if (strobe_done) begin
					if (pins_q.write_strobe_n == 1'b0) begin
						pins_d.write_strobe_n = 1'b1;
					end else begin
						phase_d = 1'b0;
						case (state_q)
							SETUP: state_d = ADDR;
							ADDR: begin
								addr_idx_d = addr_idx_q + 3'h1;
								if (addr_idx_q == addr_last)
									state_d = (req_q.op == OP_PROGRAM) ? XFER : CONFIRM;
							end
							XFER: begin
								cnt_d = cnt_q + 12'h001;
								if (cnt_q + 12'h001 == req_q.count) state_d = CONFIRM;
							end
							default: begin
								state_d = WAIT_BUSY;
								pins_d.cle = 1'b0;
								oe_n_d = 1'b1;
							end
						endcase
						cnt_d = (state_q == ADDR) ? 12'h000 : cnt_d;
					end
				end
			end
			WAIT_BUSY: begin
				// Give the device time to pull the busy line before polling it
				// Own count here: the strobe timer default would pin it at zero
				wait_d = wait_q + 16'h0001;
				if (wait_q == 16'(BUSY_START_CYCLES)) begin
					state_d = WAIT_READY;
					wait_d = 16'h0000;
				end
			end
			WAIT_READY: begin
				// Count stops one past the limit so a read overrun is flagged once
				wait_d = wait_q + 16'h0001;
				if (i_ready_busy) begin
					state_d = (req_q.op == OP_READ) ? READOUT : FINISH;
					wait_d = 16'h0000;
					cnt_d = 12'h000;
					phase_d = 1'b0;
				end else if (wait_q == 16'(BUSY_WAIT)) begin
					error_d = (req_q.op == OP_READ);
				end else if (wait_q > 16'(BUSY_WAIT)) begin
					wait_d = wait_q;
				end
			end
			READOUT: begin
				oe_n_d = 1'b1;
				if (!phase_q) begin
					pins_d.read_strobe_n = 1'b0;
					phase_d = 1'b1;
					wait_d = 16'h0000;
				end else if (strobe_done) begin
					if (!pins_q.read_strobe_n) begin
						pins_d.read_strobe_n = 1'b1;
						rd_data_d = i_shared_byte_bus;
						rd_valid_d = 1'b1;
					end else begin
						phase_d = 1'b0;
						cnt_d = cnt_q + 12'h001;
						if (cnt_q + 12'h001 == req_q.count) state_d = FINISH;
					end
				end
			end
			FINISH: begin
				pins_d.chip_sel_n = 1'b1;
				done_d = 1'b1;
				state_d = IDLE;
			end
			default: state_d = IDLE;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q     <= IDLE;
			req_q       <= '0;
			pins_q      <= '{cle: 1'b0, ale: 1'b0, chip_sel_n: 1'b1, write_strobe_n: 1'b1,
				read_strobe_n: 1'b1, protect_n: 1'b0};
			bus_q       <= 8'h00;
			oe_n_q      <= 1'b1;
			addr_idx_q  <= 3'h0;
			cnt_q       <= 12'h000;
			wait_q      <= 16'h0000;
			phase_q     <= 1'b0;
			req_ready_q <= 1'b0;
			wr_ready_q  <= 1'b0;
			rd_valid_q  <= 1'b0;
			rd_data_q   <= 8'h00;
			done_q      <= 1'b0;
			error_q     <= 1'b0;
		end else begin
			state_q     <= state_d;
			req_q       <= req_d;
			pins_q      <= pins_d;
			bus_q       <= bus_d;
			oe_n_q      <= oe_n_d;
			addr_idx_q  <= addr_idx_d;
			cnt_q       <= cnt_d;
			wait_q      <= wait_d;
			phase_q     <= phase_d;
			req_ready_q <= req_ready_d;
			wr_ready_q  <= wr_ready_d;
			rd_valid_q  <= rd_valid_d;
			rd_data_q   <= rd_data_d;
			done_q      <= done_d;
			error_q     <= error_d;
		end
	end

	assign o_req_ready            = req_ready_q;
	assign o_wr_ready             = wr_ready_q;
	assign o_rd_valid             = rd_valid_q;
	assign o_rd_data              = rd_data_q;
	assign o_done                 = done_q;
	assign o_error                = error_q;
	assign o_shared_byte_bus      = bus_q;
	assign o_shared_byte_bus_oe_n = oe_n_q;
	assign o_pins                 = pins_q;

	sequence we_pulse_s;
		$fell(pins_q.write_strobe_n) ##1 pins_q.write_strobe_n;
	endsequence

	wr_pulse_width_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		$fell(pins_q.write_strobe_n) |=> pins_q.write_strobe_n [*2])
		else $error("Write strobe cycle too short");
	wr_needs_select_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		!pins_q.write_strobe_n |-> !pins_q.chip_sel_n)
		else $error("Write strobe without chip select");
	latch_exclusive_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		!(pins_q.cle && pins_q.ale))
		else $error("Both latch strobes high");
	drive_on_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		!pins_q.write_strobe_n |-> !oe_n_q)
		else $error("Bus not driven during write strobe");
	no_clash_read_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		!pins_q.read_strobe_n |-> oe_n_q && pins_q.write_strobe_n)
		else $error("Host drives bus during read strobe");
	latch_stable_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		$fell(pins_q.write_strobe_n) |-> we_pulse_s and (1'b1 ##1 $stable(pins_q.ale)))
		else $error("Address latch changed inside write pulse");
	read_after_ready_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		(state_q == WAIT_READY && i_ready_busy) |=> state_q != WAIT_READY)
		else $error("Ready seen but still waiting");
	read_valid_rise_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
		$rose(pins_q.read_strobe_n) |-> rd_valid_q)
		else $error("Read byte not delivered at strobe rise");
endmodule : nand_host_ctrl

/* File: pkg/nand_host_pkg.sv */
// Package: command codes, timing and carrier types for the NAND host controller
package nand_host_pkg;
	localparam int unsigned CLK_PERIOD_NS     = 100;
	localparam int unsigned SERIAL_CYCLE_NS   = 25;
	localparam int unsigned STROBE_CYCLES     =
		(SERIAL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned READ_BUSY_MAX_US  = 25;
	localparam int unsigned READ_BUSY_CYCLES  = READ_BUSY_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned BUSY_START_CYCLES = 2;
	localparam int unsigned PAGE_BYTES        = 2112;
	localparam int unsigned COL_BYTES         = 2;
	localparam int unsigned ROW_BYTES         = 2;
	localparam logic [7:0]  CMD_READ_SETUP    = 8'h00;
	localparam logic [7:0]  CMD_READ_CONFIRM  = 8'h30;
	localparam logic [7:0]  CMD_PROG_SETUP    = 8'h80;
	localparam logic [7:0]  CMD_PROG_CONFIRM  = 8'h10;
	localparam logic [7:0]  CMD_ERASE_SETUP   = 8'h60;
	localparam logic [7:0]  CMD_ERASE_CONFIRM = 8'hd0;
	localparam logic [1:0]  OP_READ           = 2'h0;
	localparam logic [1:0]  OP_PROGRAM        = 2'h1;
	localparam logic [1:0]  OP_ERASE          = 2'h2;

	typedef struct packed {
		logic [1:0]  op;
		logic [15:0] column;
		logic [15:0] row;
		logic [11:0] count;
	} request_t;

	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       chip_sel_n;
		logic       write_strobe_n;
		logic       read_strobe_n;
		logic       protect_n;
	} strobes_t;
endpackage : nand_host_pkg

/* File: tb/nand_dev_model.sv */
// Behavioural NAND device that answers the host controller at its pins
`timescale 1ns/1ps
module nand_dev_model #(
	// Busy ends between clock edges so the host never races the line
	parameter int READ_NS  = 2030,
	parameter int PROG_NS  = 3030,
	parameter int ERASE_NS = 4030
) (
	input  wire nand_host_pkg::strobes_t i_pins,
	input  wire logic [7:0]              i_bus,
	output logic [7:0]                   o_bus,
	output logic                         o_ready_busy
);
	import nand_host_pkg::*;
	logic [7:0] cmd_q[$];
	logic [7:0] adr_q[$];
	logic [7:0] dat_q[$];
	logic [7:0] last_q = 8'h00;
	logic [7:0] row_lo = 8'h00;
	int         col    = 0;
	int         dur    = 0;
	event       go;
	initial o_ready_busy = 1'b1;
	// Released bus shows the inverse, so a stale byte can never pass as read data
	assign o_bus = (!i_pins.chip_sel_n && !i_pins.read_strobe_n) ? last_q : ~last_q;
	always @(posedge i_pins.write_strobe_n) begin
		if (!i_pins.chip_sel_n) begin
			if (i_pins.cle) begin
				cmd_q.push_back(i_bus);
				if (i_bus == CMD_READ_CONFIRM) begin
					col = {adr_q[$-2][3:0], adr_q[$-3]};
					row_lo = adr_q[$-1];
					dur = READ_NS;
					->go;
				end else if (i_bus inside {CMD_PROG_CONFIRM, CMD_ERASE_CONFIRM} && i_pins.protect_n) begin
					dur = (i_bus == CMD_PROG_CONFIRM) ? PROG_NS : ERASE_NS;
					->go;
				end
			end else if (i_pins.ale) begin
				adr_q.push_back(i_bus);
			end else begin
				dat_q.push_back(i_bus);
			end
		end
	end
	always @(negedge i_pins.read_strobe_n) begin
		if (!i_pins.chip_sel_n) begin
			last_q = row_lo ^ col[7:0] ^ 8'h5a;
			col++;
		end
	end
	// Busy starts only from a confirm latched while selected, then runs regardless of select, and the line reports while deselected
	always @(go) begin
		o_ready_busy = 1'b0;
		#(dur);
		o_ready_busy = 1'b1;
	end
endmodule : nand_dev_model

/* File: tb/nand_host_ctrl_tb.sv */
// Self-checking bench for the NAND host controller against a device model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin n_fail++; \
	$display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module nand_host_ctrl_tb;
	import nand_host_pkg::*;
	logic       clk = 0, rst_n = 0, req_valid = 0, bad = 0, wr_valid = 0, rb;
	logic       req_ready, wr_ready, rd_valid, done, err, oe_n, err_seen = 0;
	logic [7:0] wr_data = 8'h00, rd_data, host_bus, dev_bus, bus_res;
	request_t   req = '0;
	strobes_t   pins;
	logic [7:0] rd_q[$];
	int         seed = 13, n_fail = 0, samples_checked = 0;
	always #50 clk = ~clk;
	assign bus_res = oe_n ? dev_bus : host_bus;
	nand_host_ctrl #(.BUSY_WAIT(50)) dut_u (.I_REF_CLK(clk), .I_RST_N(rst_n),
		.i_req_valid(req_valid), .i_req(req), .i_bad_block(bad), .i_wr_valid(wr_valid),
		.i_wr_data(wr_data), .i_shared_byte_bus(bus_res), .i_ready_busy(rb),
		.o_req_ready(req_ready), .o_wr_ready(wr_ready), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_done(done), .o_error(err), .o_shared_byte_bus(host_bus),
		.o_shared_byte_bus_oe_n(oe_n), .o_pins(pins));
	nand_dev_model dev_u (.i_pins(pins), .i_bus(bus_res), .o_bus(dev_bus), .o_ready_busy(rb));
	// Pulses are taken mid-cycle, where they are settled
	always @(negedge clk) begin
		if (rd_valid === 1'b1)
			rd_q.push_back(rd_data);
		if (err === 1'b1)
			err_seen = 1'b1;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// One whole operation; expected traffic is rebuilt here from the command set
	task automatic run(input logic [1:0] op, input logic [15:0] row, input logic [15:0] col,
		input int cnt, input logic bb);
		int         k, nc, na, nd;
		logic [7:0] wd[$];
		logic [7:0] ea[$];
		logic [7:0] ec[2];
		k = 0;
		nc = dev_u.cmd_q.size();
		na = dev_u.adr_q.size();
		nd = dev_u.dat_q.size();
		rd_q.delete();
		err_seen = 1'b0;
		for (int i = 0; i < cnt; i++)
			wd.push_back(8'($random(seed)));
		if (op == OP_READ)
			ec = '{CMD_READ_SETUP, CMD_READ_CONFIRM};
		else if (op == OP_PROGRAM)
			ec = '{CMD_PROG_SETUP, CMD_PROG_CONFIRM};
		else
			ec = '{CMD_ERASE_SETUP, CMD_ERASE_CONFIRM};
		if (op != OP_ERASE)
			ea = '{col[7:0], {4'h0, col[11:8]}};
		ea.push_back(row[7:0]);
		ea.push_back(row[15:8]);
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req = '{op, col, row, 12'(cnt)};
		bad = bb;
		wr_valid = (op == OP_PROGRAM);
		wr_data = (cnt > 0) ? wd[0] : 8'h00;
		// Ready seen settled before an edge means that edge takes the request
		while (req_ready !== 1'b1 && k++ < 400) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		bad = 1'b0;
		for (int i = 1; i <= cnt && op == OP_PROGRAM; i++) begin
			do begin
				@(posedge clk);
				#1;
			end while (wr_ready !== 1'b1 && k++ < 400);
			wr_data = (i < cnt) ? wd[i] : 8'h00;
			wr_valid = (i < cnt);
		end
		while (done !== 1'b1 && k++ < 3000) begin
			@(posedge clk);
			#1;
		end
		`CHK("done", 1'b1, done)
		@(posedge clk);
		#1;
		`CHK("protect", 1'b1, pins.protect_n)
		`CHK("error", bb, err_seen)
		if (bb) begin
			`CHK("refused cmds", nc, dev_u.cmd_q.size())
		end else begin
			`CHK("setup", ec[0], dev_u.cmd_q[nc])
			`CHK("confirm", ec[1], dev_u.cmd_q[nc+1])
			foreach (ea[i])
				`CHK("addr", ea[i], dev_u.adr_q[na+i])
		end
		if (op == OP_PROGRAM)
			foreach (wd[i])
				`CHK("prog data", wd[i], dev_u.dat_q[nd+i])
		if (op == OP_READ) begin
			`CHK("read count", cnt, rd_q.size())
			foreach (rd_q[i])
				`CHK("read data", row[7:0] ^ 8'(col + i) ^ 8'h5a, rd_q[i])
		end
		`CHK("ready", 1'b1, rb)
	endtask : run
	initial begin
		repeat (2) @(posedge clk);
		#1;
		`CHK("protect in reset", 1'b0, pins.protect_n)
		rst_n = 1'b1;
		for (int r = 0; r < 9; r++)
			run(2'(r % 3), 16'($random(seed)), 16'($random(seed) & 32'h7ff),
				1 + ($random(seed) & 3), 1'b0);
		run(OP_ERASE, 16'h0123, 16'h0000, 0, 1'b1);
		run(OP_READ, 16'hffff, 16'h07fe, 4, 1'b0);
		tally_and_finish();
	end
	initial begin
		#(100 * 40000);
		n_fail++;
		tally_and_finish();
	end
endmodule : nand_host_ctrl_tb
